// >>> rtl/rtc_pkg.sv
package rtc_pkg;
  // ***********************************************************
  // register selection on the byte port
  // ***********************************************************
  localparam logic REG_SEL_TRIM  = 1'b0;
  localparam logic REG_SEL_ALARM = 1'b1;

  // ***********************************************************
  // field layout and reset values
  // ***********************************************************
  localparam int          TRIM_W        = 3;
  localparam int          TRIM_LSB      = 0;
  localparam int          ALM_EN_BIT    = 7;
  localparam int          ALM_VAL_W     = 7;
  localparam int          ALM_VAL_LSB   = 0;
  localparam logic [2:0]  TRIM_RESET    = 3'h0;
  localparam logic [7:0]  ALARM_RESET   = 8'h00;
  localparam logic [6:0]  SEC_ZERO      = 7'h00;
  localparam logic [3:0]  BCD_UNITS_MAX = 4'h9;
  localparam logic [2:0]  BCD_TENS_MAX  = 3'h5;

  // ***********************************************************
  // trim codes
  // ***********************************************************
  localparam logic [2:0] TRIM_NONE  = 3'h0;
  localparam logic [2:0] TRIM_P20   = 3'h1;
  localparam logic [2:0] TRIM_P40   = 3'h2;
  localparam logic [2:0] TRIM_P60   = 3'h3;
  localparam logic [2:0] TRIM_ZERO2 = 3'h4;
  localparam logic [2:0] TRIM_M20   = 3'h5;
  localparam logic [2:0] TRIM_M40   = 3'h6;
  localparam logic [2:0] TRIM_M60   = 3'h7;

  // ***********************************************************
  // timebase
  // ***********************************************************
  localparam int          OSC_HZ     = 32768;
  localparam int          PPM_SCALE  = 1000000;
  localparam int          CNT_W      = 17;
  localparam int          ACC_W      = 22;
  localparam logic [16:0] NOM_COUNTS = 17'h08000;

  // signed correction in ppm for a trim code
  function automatic int trim_ppm(input logic [2:0] code);
    case (code)
      TRIM_P20: trim_ppm = 20;
      TRIM_P40: trim_ppm = 40;
      TRIM_P60: trim_ppm = 60;
      TRIM_M20: trim_ppm = -20;
      TRIM_M40: trim_ppm = -40;
      TRIM_M60: trim_ppm = -60;
      default:  trim_ppm = 0;
    endcase
  endfunction

  // seven-bit bcd seconds 00..59
  function automatic logic bcd_sec_ok(input logic [6:0] v);
    bcd_sec_ok = (v[3:0] <= BCD_UNITS_MAX) && (v[6:4] <= BCD_TENS_MAX);
  endfunction
endpackage

// >>> rtl/trim_if.sv
// trim code out to the engine, corrected second tick back
interface trim_if;
  logic [2:0] code;
  logic       sec_tick;
  modport ctrl (output code, input sec_tick);
  modport eng  (input code, output sec_tick);
endinterface

// >>> rtl/trim_engine.sv
module trim_engine (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // oscillator count pulse
  input  wire logic osc_tick,
  // trim link
  trim_if.eng       trim
);
  localparam int CNT_W = rtc_pkg::CNT_W;
  localparam int ACC_W = rtc_pkg::ACC_W;

  logic [rtc_pkg::CNT_W-1:0] count_q, count_d;
  logic [rtc_pkg::CNT_W-1:0] limit_q, limit_d;
  logic [rtc_pkg::ACC_W-1:0] acc_q, acc_d;
  logic                      tick_q, tick_d;

  // ***********************************************************
  // averaged count correction
  // ***********************************************************
  // a fractional accumulator spreads the ppm over many seconds, so no
  // single second is off by more than two counts
  always_comb begin
    int                        ppm;
    logic [rtc_pkg::ACC_W-1:0] inc;
    logic [rtc_pkg::ACC_W-1:0] sum;
    logic [rtc_pkg::CNT_W-1:0] adj;
    ppm     = rtc_pkg::trim_ppm(trim.code);
    inc     = ACC_W'(((ppm < 0) ? -ppm : ppm) * rtc_pkg::OSC_HZ);
    sum     = acc_q + inc;
    adj     = '0;
    count_d = count_q;
    limit_d = limit_q;
    acc_d   = acc_q;
    tick_d  = 1'b0;
    if (sum >= ACC_W'(2 * rtc_pkg::PPM_SCALE)) begin
      adj = CNT_W'(2);
      sum = sum - ACC_W'(2 * rtc_pkg::PPM_SCALE);
    end else if (sum >= ACC_W'(rtc_pkg::PPM_SCALE)) begin
      adj = CNT_W'(1);
      sum = sum - ACC_W'(rtc_pkg::PPM_SCALE);
    end
    if (osc_tick) begin
      if (count_q >= limit_q - CNT_W'(1)) begin
        count_d = '0;
        tick_d  = 1'b1;
        acc_d   = sum;
        // positive trims shorten the second, negative ones stretch it
        limit_d = (ppm >= 0) ? rtc_pkg::NOM_COUNTS - adj
                             : rtc_pkg::NOM_COUNTS + adj;
      end else begin
        count_d = count_q + CNT_W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      limit_q <= rtc_pkg::NOM_COUNTS;
      acc_q   <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      limit_q <= limit_d;
      acc_q   <= acc_d;
      tick_q  <= tick_d;
    end
  end

  assign trim.sec_tick = tick_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_no_trim_nominal;
    @(posedge ref_clk) disable iff (rst)
    (tick_q && trim.code == rtc_pkg::TRIM_NONE && $stable(trim.code))
      |-> limit_q == rtc_pkg::NOM_COUNTS;
  endproperty
  a_no_trim_nominal: assert property (p_no_trim_nominal)
    else $error("untrimmed second not nominal length");

  property p_limit_bounded;
    @(posedge ref_clk) disable iff (rst)
    (limit_q >= rtc_pkg::NOM_COUNTS - CNT_W'(2)) &&
    (limit_q <= rtc_pkg::NOM_COUNTS + CNT_W'(2));
  endproperty
  a_limit_bounded: assert property (p_limit_bounded)
    else $error("second length correction too large");

  property p_pos_shortens;
    @(posedge ref_clk) disable iff (rst)
    (tick_q && rtc_pkg::trim_ppm($past(trim.code)) > 0)
      |-> limit_q <= rtc_pkg::NOM_COUNTS;
  endproperty
  a_pos_shortens: assert property (p_pos_shortens)
    else $error("positive trim lengthened a second");

  property p_tick_single;
    @(posedge ref_clk) disable iff (rst)
    tick_q |=> !tick_q [*2];
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("second tick wider than one cycle");
endmodule

// >>> rtl/rtc_trim_and_alarm_seconds.sv
module rtc_trim_and_alarm_seconds (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // register byte port behind the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_sel,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // timebase
  input  wire logic       osc_tick,
  output logic            sec_tick,
  // running clock and alarm
  input  wire logic [6:0] running_seconds,
  output logic            alarm_match,
  output logic            alarm_pulse
);
  localparam int TW = rtc_pkg::TRIM_W;
  localparam int VW = rtc_pkg::ALM_VAL_W;

  logic [TW-1:0] trim_q, trim_d;
  logic [VW-1:0] alm_val_q, alm_val_d;
  logic          alm_en_q, alm_en_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          match_q, match_d;
  logic          pulse_q, pulse_d;
  logic          match_now;

  trim_if trim ();

  // ***********************************************************
  // register file
  // ***********************************************************
  // the alarm register has no nonvolatile copy: reset clears it
  always_comb begin
    trim_d    = trim_q;
    alm_val_d = alm_val_q;
    alm_en_d  = alm_en_q;
    if (reg_wr) begin
      if (reg_sel == rtc_pkg::REG_SEL_TRIM) begin
        trim_d = reg_wdata[rtc_pkg::TRIM_LSB +: TW];
      end else begin
        alm_val_d = reg_wdata[rtc_pkg::ALM_VAL_LSB +: VW];
        alm_en_d  = reg_wdata[rtc_pkg::ALM_EN_BIT];
      end
    end
    // read data shows the stored fields, unused bits zero
    if (reg_sel == rtc_pkg::REG_SEL_TRIM) begin
      rdata_d = {5'h00, trim_q};
    end else begin
      rdata_d = {alm_en_q, alm_val_q};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trim_q    <= rtc_pkg::TRIM_RESET;
      alm_val_q <= rtc_pkg::ALARM_RESET[rtc_pkg::ALM_VAL_LSB +: VW];
      alm_en_q  <= rtc_pkg::ALARM_RESET[rtc_pkg::ALM_EN_BIT];
      rdata_q   <= 8'h00;
    end else begin
      trim_q    <= trim_d;
      alm_val_q <= alm_val_d;
      alm_en_q  <= alm_en_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ***********************************************************
  // frequency trim
  // ***********************************************************
  assign trim.code = trim_q;
  assign sec_tick  = trim.sec_tick;

  trim_engine u_trim (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .osc_tick (osc_tick),
    .trim     (trim)
  );

  // ***********************************************************
  // seconds alarm
  // ***********************************************************
  // an out-of-range stored value never matches, so a bad write cannot
  // fire the alarm on garbage; keeping it valid is up to software
  assign match_now = alm_en_q &&
                     rtc_pkg::bcd_sec_ok(alm_val_q) &&
                     (alm_val_q == running_seconds);

  // one pulse per match, on its rising edge
  always_comb begin
    match_d = match_now;
    pulse_d = match_now && !match_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      match_q <= match_d;
      pulse_q <= pulse_d;
    end
  end

  assign alarm_match = match_q;
  assign alarm_pulse = pulse_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_disabled_quiet;
    @(posedge ref_clk) disable iff (rst)
    !$past(alm_en_q) |-> !alarm_match && !alarm_pulse;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("alarm fired while seconds byte disabled");

  property p_enabled_match;
    @(posedge ref_clk) disable iff (rst)
    (alm_en_q && alm_val_q == running_seconds && rtc_pkg::bcd_sec_ok(alm_val_q))
      |=> alarm_match;
  endproperty
  a_enabled_match: assert property (p_enabled_match)
    else $error("enabled equal seconds did not match");

  property p_pulse_cause;
    @(posedge ref_clk) disable iff (rst)
    alarm_pulse |-> alarm_match && !$past(alarm_match) &&
                    $past(running_seconds) == $past(alm_val_q);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("alarm pulse without fresh equal seconds");

  property p_alarm_readback;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_sel == rtc_pkg::REG_SEL_ALARM)
      ##1 (!reg_wr && reg_sel == rtc_pkg::REG_SEL_ALARM)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_alarm_readback: assert property (p_alarm_readback)
    else $error("alarm seconds readback differs from write");

  property p_trim_readback;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_sel == rtc_pkg::REG_SEL_TRIM)
      ##1 (!reg_wr && reg_sel == rtc_pkg::REG_SEL_TRIM)
      |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)};
  endproperty
  a_trim_readback: assert property (p_trim_readback)
    else $error("trim readback differs from write");

  property p_bad_bcd_quiet;
    @(posedge ref_clk) disable iff (rst)
    !rtc_pkg::bcd_sec_ok(alm_val_q) |=> !alarm_match;
  endproperty
  a_bad_bcd_quiet: assert property (p_bad_bcd_quiet)
    else $error("invalid bcd alarm value matched");

  // the second tick only ever follows an oscillator count
  property p_tick_from_osc;
    @(posedge ref_clk) disable iff (rst)
    sec_tick |-> $past(osc_tick);
  endproperty
  a_tick_from_osc: assert property (p_tick_from_osc)
    else $error("second tick without an oscillator count");

  // a match always traces back to an enabled, equal seconds pair one cycle earlier
  property p_match_source;
    @(posedge ref_clk) disable iff (rst)
    alarm_match |-> $past(alm_en_q) && ($past(alm_val_q) == $past(running_seconds));
  endproperty
  a_match_source: assert property (p_match_source)
    else $error("alarm match without enabled equal seconds");

  property p_match_valid_bcd;
    @(posedge ref_clk) disable iff (rst)
    alarm_match |-> rtc_pkg::bcd_sec_ok($past(alm_val_q));
  endproperty
  a_match_valid_bcd: assert property (p_match_valid_bcd)
    else $error("alarm matched on an invalid seconds value");

  property p_pulse_once;
    @(posedge ref_clk) disable iff (rst)
    alarm_pulse |=> !alarm_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once)
    else $error("alarm pulse longer than one cycle");

  // written trim bits reach the engine on the next edge, not at the next wrap
  property p_trim_reaches_engine;
    @(posedge ref_clk) disable iff (rst)
    (!$past(rst) && $past(reg_wr) && $past(reg_sel) == rtc_pkg::REG_SEL_TRIM)
      |-> trim.code == $past(reg_wdata[rtc_pkg::TRIM_LSB +: TW]);
  endproperty
  a_trim_reaches_engine: assert property (p_trim_reaches_engine)
    else $error("written trim code not applied");

  property p_trim_upper_zero;
    @(posedge ref_clk) disable iff (rst)
    ($past(reg_sel) == rtc_pkg::REG_SEL_TRIM) |-> reg_rdata[7:TW] == '0;
  endproperty
  a_trim_upper_zero: assert property (p_trim_upper_zero)
    else $error("unused trim bits read back nonzero");

  // enable bit sits above the seven-bit value in the read byte
  property p_alarm_fields_read;
    @(posedge ref_clk) disable iff (rst)
    ($past(reg_sel) == rtc_pkg::REG_SEL_ALARM)
      |-> reg_rdata == {$past(alm_en_q), $past(alm_val_q)};
  endproperty
  a_alarm_fields_read: assert property (p_alarm_fields_read)
    else $error("alarm register fields read back misplaced");
endmodule

// >>> test/host_model.sv
// ***********************************************************
// host side of the register byte port
// ***********************************************************
module host_model (
  // clock
  input  wire logic       ref_clk,
  // byte port toward the device
  output logic            reg_wr,
  output logic            reg_sel,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle port: no strobe, first register selected
  initial begin
    reg_wr    = 1'b0;
    reg_sel   = 1'b0;
    reg_wdata = 8'h00;
  end

  // one byte write, strobe held across exactly one rising edge
  task automatic write_reg(input logic sel, input logic [7:0] data);
    @(negedge ref_clk);
    reg_wr    = 1'b1;
    reg_sel   = sel;
    reg_wdata = data;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~data; // released data must not look like the last byte
  endtask

  // pick which register the read path shows
  task automatic select_reg(input logic sel);
    @(negedge ref_clk);
    reg_sel = sel;
  endtask
endmodule

// >>> test/tb_rtc_trim_and_alarm_seconds.sv
// ***********************************************************
// bench for trim and seconds alarm
// ***********************************************************
module tb_rtc_trim_and_alarm_seconds;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, rst, reg_wr, reg_sel, osc_tick, sec_tick, alarm_match, alarm_pulse;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] running_seconds;
  int         failures, tests_run, cnt;
  int         lens[$];

  // 20 MHz clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  rtc_trim_and_alarm_seconds u_rtc_trim_and_alarm_seconds (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
    .sec_tick(sec_tick), .running_seconds(running_seconds),
    .alarm_match(alarm_match), .alarm_pulse(alarm_pulse));

  host_model u_host_model (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata));

  // length of each second in osc ticks, measured between sec_tick pulses
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
    end else if (sec_tick) begin
      lens.push_back(cnt);
      cnt <= int'(osc_tick);
    end else begin
      cnt <= cnt + int'(osc_tick);
    end
  end

  // ***********************************************************
  // shared helpers
  // ***********************************************************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read path is registered, so two edges pass before sampling
  task automatic read_check(input string what, input logic sel, input logic [7:0] exp);
    u_host_model.select_reg(sel);
    repeat (2) @(negedge ref_clk);
    check8(what, exp, reg_rdata);
  endtask

  task automatic alarm_check(input logic exp_match, input logic exp_pulse);
    check8("alarm_match", {7'h00, exp_match}, {7'h00, alarm_match});
    check8("alarm_pulse", {7'h00, exp_pulse}, {7'h00, alarm_pulse});
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic test_reset;
    read_check("trim reset", rtc_pkg::REG_SEL_TRIM, 8'h00);
    read_check("alarm reset", rtc_pkg::REG_SEL_ALARM, 8'h00);
    $display("test reset done");
  endtask

  // every trim code, upper bits written high to see them dropped
  task automatic test_trim_codes;
    for (int i = 0; i < 8; i++) begin
      u_host_model.write_reg(rtc_pkg::REG_SEL_TRIM, {5'h1f, 3'(i)});
      read_check("trim code", rtc_pkg::REG_SEL_TRIM, {5'h00, 3'(i)});
    end
    $display("test trim codes done");
  endtask

  task automatic test_alarm_match;
    running_seconds = 7'h58;
    u_host_model.write_reg(rtc_pkg::REG_SEL_ALARM, 8'hd9);
    read_check("alarm rw", rtc_pkg::REG_SEL_ALARM, 8'hd9);
    alarm_check(1'b0, 1'b0);
    running_seconds = 7'h59;
    @(negedge ref_clk);
    alarm_check(1'b1, 1'b1);
    @(negedge ref_clk);
    alarm_check(1'b1, 1'b0);
    u_host_model.write_reg(rtc_pkg::REG_SEL_ALARM, 8'h59);
    repeat (2) @(negedge ref_clk);
    alarm_check(1'b0, 1'b0);
    running_seconds = 7'h00;
    u_host_model.write_reg(rtc_pkg::REG_SEL_ALARM, 8'h80);
    repeat (2) @(negedge ref_clk);
    alarm_check(1'b1, 1'b0);
    // invalid bcd is stored but must never match
    running_seconds = 7'h7a;
    u_host_model.write_reg(rtc_pkg::REG_SEL_ALARM, 8'hfa);
    repeat (3) @(negedge ref_clk);
    alarm_check(1'b0, 1'b0);
    $display("test alarm match done");
  endtask

  // +60 ppm shortens a second by one or two ticks, -60 ppm stretches one, the first second after
  // reset is nominal; each code is written during the second whose wrap applies it
  task automatic test_trim_timebase;
    logic [7:0] code;
    for (int k = 0; k < 3; k++) begin
      code = (k == 0) ? {5'h00, rtc_pkg::TRIM_P60} :
             (k == 1) ? {5'h00, rtc_pkg::TRIM_M60} : {5'h00, rtc_pkg::TRIM_NONE};
      u_host_model.write_reg(rtc_pkg::REG_SEL_TRIM, code);
      for (int i = 0; i < 33000 && lens.size() <= k; i++) @(negedge ref_clk);
    end
    tests_run++;
    if (lens.size() < 3) begin
      failures++;
      $display("MISMATCH seconds seen expected 3 seen %0d", lens.size());
    end else begin
      tests_run++;
      if (lens[0] != rtc_pkg::OSC_HZ) begin
        failures++;
        $display("MISMATCH first second expected %0d seen %0d", rtc_pkg::OSC_HZ, lens[0]);
      end
      tests_run++;
      if (lens[1] < rtc_pkg::OSC_HZ - 2 || lens[1] > rtc_pkg::OSC_HZ - 1) begin
        failures++;
        $display("MISMATCH plus60 second expected 32766..32767 seen %0d", lens[1]);
      end
      tests_run++;
      if (lens[2] < rtc_pkg::OSC_HZ + 1 || lens[2] > rtc_pkg::OSC_HZ + 2) begin
        failures++;
        $display("MISMATCH minus60 second expected 32769..32770 seen %0d", lens[2]);
      end
    end
    $display("test trim timebase done");
  endtask

  // watchdog sized for three seconds of ticks plus margin
  initial begin
    #(101000 * 50);
    failures++;
    give_verdict();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    failures        = 0;
    tests_run       = 0;
    rst             = 1'b1;
    osc_tick        = 1'b0;
    running_seconds = 7'h00;
    repeat (10) @(negedge ref_clk);
    rst      = 1'b0;
    osc_tick = 1'b1; // one tick every cycle keeps the run short
    test_reset();
    test_trim_codes();
    test_alarm_match();
    test_trim_timebase();
    give_verdict();
  end
endmodule
